// File: core/hmi_irq_status.sv
// Host MAC and FIFO interrupt status, enable and threshold registers with IRQ output.
// Assumes event inputs are single-clock pulses or levels from logic on clk.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Receive error sets status bit 14; writing one clears it.
// R2 - Transmit error sets status bit 13; writing one clears it.
// R3 - Bit 12 is read-only and mirrors the pending pin event summary.
// R4 - Write attempt into a full transmit data FIFO sets bit 10.
// R5 - Transmit data free space above its threshold sets bit 9.
// R6 - Transmit status FIFO becoming full sets bit 8.
// R7 - Transmit status fill exceeding its threshold sets bit 7.
// R8 - Every dropped receive frame sets bit 6.
// R9 - Receive status FIFO becoming full sets bit 4.
// R10 - Receive status fill exceeding its threshold sets bit 3.
// R11 - A flag drives the interrupt only with its enable bit set.
// R12 - Flags latch events regardless of their enable bits.
// R13 - Threshold fields 31:24 (64-byte blocks, reset 48h), 23:16 and 7:0 words.
// R14 - Bits 11 and 5 read zero; writing zero leaves flags unchanged.
// R15 - A set arriving with a clear of the same flag keeps it set.
module hmi_irq_status
   import hmi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rxErrorEvent,
   input wire logic txErrorEvent,
   input wire logic pinEventPending,
   input wire logic txDataWriteAttempt,
   input wire logic txDataFifoFull,
   input wire logic [7:0] txDataFreeBlocks,
   input wire logic txStatusFifoFull,
   input wire logic [7:0] txStatusUsedWords,
   input wire logic rxFrameDropped,
   input wire logic rxStatusFifoFull,
   input wire logic [7:0] rxStatusUsedWords,
   output logic irq
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      hmi_bus_state_type busState;
      logic waitReq;
      logic [31:0] readData;
      logic [31:0] flags;
      logic [31:0] enable;
      logic [31:0] fifoLevel;
      logic txStatusFullSeen;
      logic rxStatusFullSeen;
      logic irq;
   } hmi_state_type;

   hmi_state_type st;
   hmi_state_type next_st;

   logic [HMI_LVL_COUNT-1:0] levelRise;
   logic [7:0] levelCount [HMI_LVL_COUNT];
   logic [7:0] levelThreshold [HMI_LVL_COUNT];

   // ****************************************************************
   // Threshold watchers.
   // ****************************************************************
   assign levelCount[HMI_LVL_TX_DATA] = txDataFreeBlocks;
   assign levelCount[HMI_LVL_TX_STATUS] = txStatusUsedWords;
   assign levelCount[HMI_LVL_RX_STATUS] = rxStatusUsedWords;
   // R13
   assign levelThreshold[HMI_LVL_TX_DATA] =
      st.fifoLevel[HMI_FLD_TX_DATA_LSB +: HMI_FLD_WIDTH];
   assign levelThreshold[HMI_LVL_TX_STATUS] =
      st.fifoLevel[HMI_FLD_TX_STATUS_LSB +: HMI_FLD_WIDTH];
   assign levelThreshold[HMI_LVL_RX_STATUS] =
      st.fifoLevel[HMI_FLD_RX_STATUS_LSB +: HMI_FLD_WIDTH];

   genvar gi;
   generate
      for (gi = 0; gi < HMI_LVL_COUNT; gi++) begin : g_level
         hmi_level_watch u_watch (
            .clk(clk),
            .sys_rst(sys_rst),
            .count(levelCount[gi]),
            .threshold(levelThreshold[gi]),
            .rise(levelRise[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   logic [31:0] setEvents;
   logic [31:0] clearBits;
   logic [31:0] byteMask;
   logic [31:0] readMux;
   logic commit;
   logic hitStatus;
   logic hitEnable;
   logic hitLevel;

   always_comb begin
      next_st = st;
      setEvents = '0;
      clearBits = '0;
      byteMask = '0;
      readMux = '0;
      commit = 1'b0;
      hitStatus = avs_address[7:2] == HMI_OFS_STATUS[7:2];
      hitEnable = avs_address[7:2] == HMI_OFS_ENABLE[7:2];
      hitLevel = avs_address[7:2] == HMI_OFS_FIFO_LEVEL[7:2];
      for (int b = 0; b < 4; b++) begin
         byteMask[b*8 +: 8] = {8{avs_byteenable[b]}};
      end

      // ****************************************************************
      // Event capture.
      // ****************************************************************
      // Events are gathered without regard to the enable word.
      setEvents[HMI_BIT_RECEIVE_ERROR] = rxErrorEvent; // R1 R12
      setEvents[HMI_BIT_TRANSMIT_ERROR] = txErrorEvent; // R2
      setEvents[HMI_BIT_TX_DATA_OVERRUN] = txDataWriteAttempt && txDataFifoFull; // R4
      setEvents[HMI_BIT_TX_DATA_SPACE] = levelRise[HMI_LVL_TX_DATA]; // R5
      setEvents[HMI_BIT_TX_STATUS_FULL] = txStatusFifoFull && !st.txStatusFullSeen; // R6
      setEvents[HMI_BIT_TX_STATUS_LEVEL] = levelRise[HMI_LVL_TX_STATUS]; // R7
      setEvents[HMI_BIT_RX_FRAME_DROPPED] = rxFrameDropped; // R8
      setEvents[HMI_BIT_RX_STATUS_FULL] = rxStatusFifoFull && !st.rxStatusFullSeen; // R9
      setEvents[HMI_BIT_RX_STATUS_LEVEL] = levelRise[HMI_LVL_RX_STATUS]; // R10
      next_st.txStatusFullSeen = txStatusFifoFull;
      next_st.rxStatusFullSeen = rxStatusFifoFull;

      // Read data are latched one cycle ahead of the answer, so the mux sees a stable address.
      if (hitStatus) begin
         readMux = st.flags;
      end else if (hitEnable) begin
         readMux = st.enable;
      end else if (hitLevel) begin
         readMux = st.fifoLevel;
      end

      // ****************************************************************
      // Bus answer.
      // ****************************************************************
      // A write lands only at the answer edge, where the master still holds its data.
      unique case (st.busState)
         HMI_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_st.busState = HMI_BUS_ANSWER;
               next_st.waitReq = 1'b0;
               next_st.readData = readMux;
            end
         end
         HMI_BUS_ANSWER: begin
            commit = avs_write;
            next_st.busState = HMI_BUS_IDLE;
            next_st.waitReq = 1'b1;
         end
         default: begin
            next_st.busState = HMI_BUS_IDLE;
            next_st.waitReq = 1'b1;
         end
      endcase

      // ****************************************************************
      // Register writes.
      // ****************************************************************
      // Byte lanes let software touch one threshold without rewriting the others.
      if (commit && hitStatus) begin
         clearBits = avs_writedata & byteMask & HMI_CLEAR_MASK; // R14
      end
      if (commit && hitEnable) begin
         next_st.enable = ((avs_writedata & byteMask) | (st.enable & ~byteMask))
            & HMI_ENABLE_MASK;
      end
      if (commit && hitLevel) begin
         next_st.fifoLevel = (avs_writedata & byteMask) | (st.fifoLevel & ~byteMask); // R13
      end

      // Set wins over clear so an event in the clearing cycle is kept.
      next_st.flags = ((st.flags & ~clearBits) | setEvents) & HMI_CLEAR_MASK; // R15 R14
      next_st.flags[HMI_BIT_PIN_EVENT] = pinEventPending; // R3

      next_st.irq = |(next_st.flags & next_st.enable); // R11
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st.busState <= HMI_BUS_IDLE;
         st.waitReq <= 1'b1;
         st.readData <= 32'h0000_0000;
         st.flags <= HMI_STATUS_RST;
         st.enable <= HMI_ENABLE_RST;
         st.fifoLevel <= HMI_FIFO_LEVEL_RST;
         st.txStatusFullSeen <= 1'b0;
         st.rxStatusFullSeen <= 1'b0;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata = st.readData;
   assign avs_waitrequest = st.waitReq;
   assign irq = st.irq;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_RX_ERROR_SETS: assert property (rxErrorEvent |=> st.flags[14]) // R1
      else $error("Receive error did not set bit 14.");

   AST_RX_ERROR_CLEARS: assert property ( // R1
      (commit && hitStatus && avs_writedata[14] && avs_byteenable[1] && !rxErrorEvent)
      |=> !st.flags[14])
      else $error("Writing one did not clear bit 14.");

   AST_TX_ERROR_SETS: assert property (txErrorEvent |=> st.flags[13]) // R2
      else $error("Transmit error did not set bit 13.");

   AST_TX_ERROR_HOLDS: assert property ( // R2
      (st.flags[13] && !(commit && hitStatus && avs_writedata[13] && avs_byteenable[1]))
      |=> st.flags[13])
      else $error("Transmit error flag dropped without a clear.");

   AST_PIN_EVENT_MIRROR: assert property (##1 st.flags[12] == $past(pinEventPending)) // R3
      else $error("Bit 12 does not follow the pin event summary.");

   AST_OVERRUN_SETS: assert property ( // R4
      (txDataWriteAttempt && txDataFifoFull) |=> st.flags[10])
      else $error("Overrun did not set bit 10.");

   // The level checks skip cycles in which the threshold moves, because the watcher
   // then still holds a compare against the older value.
   AST_SPACE_SETS: assert property ( // R5
      (txDataFreeBlocks > st.fifoLevel[31:24] && $stable(st.fifoLevel)
       && $past(txDataFreeBlocks) <= $past(st.fifoLevel[31:24])) |=> ##1 st.flags[9])
      else $error("Free space above threshold did not set bit 9.");

   AST_TX_LEVEL_SETS: assert property ( // R7
      (txStatusUsedWords > st.fifoLevel[23:16] && $stable(st.fifoLevel)
       && $past(txStatusUsedWords) <= $past(st.fifoLevel[23:16])) |=> ##1 st.flags[7])
      else $error("Transmit status fill above threshold did not set bit 7.");

   AST_RX_LEVEL_SETS: assert property ( // R10
      (rxStatusUsedWords > st.fifoLevel[7:0] && $stable(st.fifoLevel)
       && $past(rxStatusUsedWords) <= $past(st.fifoLevel[7:0])) |=> ##1 st.flags[3])
      else $error("Receive status fill above threshold did not set bit 3.");

   AST_TX_FULL_SETS: assert property ($rose(txStatusFifoFull) |=> st.flags[8]) // R6
      else $error("Transmit status full did not set bit 8.");

   AST_TX_FULL_ONCE: assert property ( // R6
      (txStatusFifoFull && $past(txStatusFifoFull) && !$past(sys_rst) && !st.flags[8])
      |=> !st.flags[8])
      else $error("Transmit status full set bit 8 again without a new edge.");

   AST_DROP_UNMASKED: assert property ( // R8 R12
      (rxFrameDropped && !st.enable[6]) |=> st.flags[6])
      else $error("Dropped frame not latched while disabled.");

   AST_RX_FULL_SETS: assert property ($rose(rxStatusFifoFull) |=> st.flags[4]) // R9
      else $error("Receive status full did not set bit 4.");

   AST_IRQ_GATED: assert property (irq == |(st.flags & st.enable)) // R11
      else $error("Interrupt output disagrees with enabled flags.");

   AST_ENABLE_WRITE: assert property ( // R11
      (commit && hitEnable && avs_byteenable == 4'hF)
      |=> st.enable == ($past(avs_writedata) & HMI_ENABLE_MASK))
      else $error("Enable register did not take a full-word write.");

   AST_RESERVED_ZERO: assert property ( // R14
      !st.flags[11] && !st.flags[5] && !st.enable[11] && !st.enable[5])
      else $error("Reserved bit reads nonzero.");

   AST_WRITE_ZERO_KEEPS: assert property ( // R14
      (commit && hitStatus && avs_writedata == 32'h0000_0000)
      |=> (st.flags & $past(st.flags) & HMI_CLEAR_MASK) == ($past(st.flags) & HMI_CLEAR_MASK))
      else $error("Writing zero changed a status flag.");

   AST_LEVEL_RESET: assert property ( // R13
      $fell(sys_rst) |-> st.fifoLevel == HMI_FIFO_LEVEL_RST)
      else $error("Threshold register reset value wrong.");

   AST_LEVEL_WRITE: assert property ( // R13
      (commit && hitLevel && avs_byteenable == 4'hF) |=> st.fifoLevel == $past(avs_writedata))
      else $error("Threshold register did not take a full-word write.");

   AST_SET_BEATS_CLEAR: assert property ( // R15
      (rxErrorEvent && commit && hitStatus && avs_writedata[14] && avs_byteenable[1])
      |=> st.flags[14])
      else $error("Event lost against a simultaneous clear.");

   AST_BUS_ANSWER: assert property (
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Bus answer not given in one wait cycle.");

endmodule

`default_nettype wire

// File: core/hmi_level_watch.sv
// Threshold watcher: pulses rise for one cycle, the cycle after a FIFO count first exceeds its level.
// Assumes count and threshold come from logic on the same clock.

`timescale 1ns/1ps
`default_nettype none

module hmi_level_watch
   import hmi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] count,
   input wire logic [7:0] threshold,
   output logic rise
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic above;
      logic rise;
   } hmi_watch_state_type;

   hmi_watch_state_type st;
   hmi_watch_state_type next_st;

   // An edge, not the level, so a cleared flag stays clear while the FIFO sits above.
   always_comb begin
      next_st = st;
      next_st.above = count > threshold;
      next_st.rise = next_st.above && !st.above;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise = st.rise;

endmodule

`default_nettype wire

// File: include/hmi_pkg.sv
// Constants and types shared by the host MAC / FIFO interrupt status block.
// Assumes one core clock and a 32-bit Avalon-MM register port.

package hmi_pkg;

   // ****************************************************************
   // Register byte offsets.
   // ****************************************************************
   localparam logic [7:0] HMI_OFS_STATUS = 8'h58;
   localparam logic [7:0] HMI_OFS_ENABLE = 8'h5C;
   localparam logic [7:0] HMI_OFS_FIFO_LEVEL = 8'h68;

   // ****************************************************************
   // Status and enable bit positions.
   // ****************************************************************
   localparam int HMI_BIT_RECEIVE_ERROR = 14;
   localparam int HMI_BIT_TRANSMIT_ERROR = 13;
   localparam int HMI_BIT_PIN_EVENT = 12;
   localparam int HMI_BIT_RSVD_HIGH = 11;
   localparam int HMI_BIT_TX_DATA_OVERRUN = 10;
   localparam int HMI_BIT_TX_DATA_SPACE = 9;
   localparam int HMI_BIT_TX_STATUS_FULL = 8;
   localparam int HMI_BIT_TX_STATUS_LEVEL = 7;
   localparam int HMI_BIT_RX_FRAME_DROPPED = 6;
   localparam int HMI_BIT_RSVD_LOW = 5;
   localparam int HMI_BIT_RX_STATUS_FULL = 4;
   localparam int HMI_BIT_RX_STATUS_LEVEL = 3;

   // Bits that exist in the enable word, and bits that software may clear.
   localparam logic [31:0] HMI_ENABLE_MASK = 32'h0000_77D8;
   localparam logic [31:0] HMI_CLEAR_MASK = 32'h0000_67D8;

   // ****************************************************************
   // Threshold register fields and reset values.
   // ****************************************************************
   localparam int HMI_FLD_TX_DATA_LSB = 24;
   localparam int HMI_FLD_TX_STATUS_LSB = 16;
   localparam int HMI_FLD_RX_STATUS_LSB = 0;
   localparam int HMI_FLD_WIDTH = 8;
   localparam logic [31:0] HMI_STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] HMI_ENABLE_RST = 32'h0000_0000;
   localparam logic [31:0] HMI_FIFO_LEVEL_RST = 32'h4800_0000;

   // ****************************************************************
   // Level watcher indices.
   // ****************************************************************
   localparam int HMI_LVL_TX_DATA = 0;
   localparam int HMI_LVL_TX_STATUS = 1;
   localparam int HMI_LVL_RX_STATUS = 2;
   localparam int HMI_LVL_COUNT = 3;

   typedef enum logic [1:0] {
      HMI_BUS_IDLE = 2'b01,
      HMI_BUS_ANSWER = 2'b10
   } hmi_bus_state_type;

endpackage

// File: test/hmi_host_model.sv
// Host processor model: Avalon-MM master with one word per access.
// Assumes it runs on the block's clock and that the bench top owns the mismatch count.

`timescale 1ns/1ps
`default_nettype none

module hmi_host_model
   import hmi_pkg::*;
(
   input wire logic clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   // Byte lanes of the next access; the bench narrows them for lane tests only.
   logic [3:0] lanes = 4'hF;

   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
   end

   // The request is held until waitrequest is sampled low; data is taken at that edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= lanes;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         host_mac_fifo_irq_status_tb_top.mismatches++;
         host_mac_fifo_irq_status_tb_top.close_out();
      end
   endtask
endmodule

`default_nettype wire

// File: test/host_mac_fifo_irq_status_tb_top.sv
// Self-checking bench for the interrupt status, enable and threshold registers.
// Assumes the host model's bus tasks and direct drive of the event inputs.

`timescale 1ns/1ps
`default_nettype none

module host_mac_fifo_irq_status_tb_top;
   import hmi_pkg::*;
   logic clk, sys_rst, irq, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic receive_error_flag, transmit_error_flag, pin, att, dFull, sFull, rFull, drop;
   logic [7:0] dFree, sUsed, rUsed;
   int mismatches = 0;
   int samples_checked = 0;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   hmi_host_model i_hmi_host_model(.clk(clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   hmi_irq_status i_hmi_irq_status(.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxErrorEvent(receive_error_flag), .txErrorEvent(transmit_error_flag),
      .pinEventPending(pin), .txDataWriteAttempt(att), .txDataFifoFull(dFull),
      .txDataFreeBlocks(dFree), .txStatusFifoFull(sFull), .txStatusUsedWords(sUsed),
      .rxFrameDropped(drop), .rxStatusFifoFull(rFull), .rxStatusUsedWords(rUsed),
      .irq(irq));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      i_hmi_host_model.xfer(1'b0, a, 32'h0000_0000, q);
      chk(name, q, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_hmi_host_model.xfer(1'b1, a, d, q);
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic close_out();
      $display("compared %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      {receive_error_flag, transmit_error_flag, pin, att, dFull, sFull, rFull, drop} = 8'h00;
      {dFree, sUsed, rUsed} = 24'h00_0000;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(HMI_OFS_STATUS, 32'h0000_0000, "status reset");
      rd(HMI_OFS_ENABLE, 32'h0000_0000, "enable reset");
      rd(HMI_OFS_FIFO_LEVEL, 32'h4800_0000, "level reset");
      rd(8'h40, 32'h0000_0000, "unmapped");
      wr(HMI_OFS_ENABLE, 32'hFFFF_FFFF);
      rd(HMI_OFS_ENABLE, 32'h0000_77D8, "enable bits");
      wr(HMI_OFS_ENABLE, 32'h0000_0000);
      $display("test registers done");
      // All pulse and FIFO-full edge events at once, plus the pin level; each lands in its own bit.
      @(posedge clk);
      {receive_error_flag, transmit_error_flag, att, dFull, sFull, rFull, drop, pin} <= 8'hFF;
      @(posedge clk);
      {receive_error_flag, transmit_error_flag, att, drop} <= 4'h0;
      repeat (3) @(posedge clk);
      rd(HMI_OFS_STATUS, 32'h0000_7550, "event flags");
      irq_is(1'b0);
      wr(HMI_OFS_STATUS, 32'h0000_0000);
      rd(HMI_OFS_STATUS, 32'h0000_7550, "write zero");
      wr(HMI_OFS_STATUS, 32'hFFFF_FFFF);
      rd(HMI_OFS_STATUS, 32'h0000_1000, "clear all");
      $display("test events done");
      wr(HMI_OFS_FIFO_LEVEL, 32'h0503_0002);
      rd(HMI_OFS_FIFO_LEVEL, 32'h0503_0002, "levels");
      // Counts equal to the levels must not fire: the compare is strictly greater.
      {dFree, sUsed, rUsed} <= 24'h05_0302;
      repeat (4) @(posedge clk);
      rd(HMI_OFS_STATUS, 32'h0000_1000, "at level");
      {dFree, sUsed, rUsed} <= 24'h06_0403;
      repeat (4) @(posedge clk);
      rd(HMI_OFS_STATUS, 32'h0000_1288, "above level");
      $display("test levels done");
      wr(HMI_OFS_ENABLE, 32'h0000_4000);
      irq_is(1'b0);
      wr(HMI_OFS_ENABLE, 32'h0000_0008);
      irq_is(1'b1);
      wr(HMI_OFS_STATUS, 32'h0000_0008);
      irq_is(1'b0);
      rd(HMI_OFS_STATUS, 32'h0000_1280, "one cleared");
      $display("test irq done");
      @(posedge clk);
      drop <= 1'b1;
      wr(HMI_OFS_STATUS, 32'h0000_0040);
      drop <= 1'b0;
      pin <= 1'b0;
      repeat (2) @(posedge clk);
      rd(HMI_OFS_STATUS, 32'h0000_02C0, "set beats clear");
      $display("test collision done");
      // Byte lanes: only lane 0 of each write may land.
      i_hmi_host_model.lanes = 4'h1;
      wr(HMI_OFS_STATUS, 32'hFFFF_FFFF);
      wr(HMI_OFS_FIFO_LEVEL, 32'hFFFF_FFFF);
      i_hmi_host_model.lanes = 4'hF;
      rd(HMI_OFS_STATUS, 32'h0000_0200, "lane clear");
      rd(HMI_OFS_FIFO_LEVEL, 32'h0503_00FF, "lane write");
      wr(HMI_OFS_ENABLE, 32'h0000_0200);
      irq_is(1'b1);
      $display("test lanes done");
      // Reset in mid-run; FIFO inputs go idle first so no level or full edge follows release.
      @(posedge clk);
      {dFull, sFull, rFull} <= 3'h0;
      {dFree, sUsed, rUsed} <= 24'h00_0000;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(HMI_OFS_FIFO_LEVEL, HMI_FIFO_LEVEL_RST, "level after reset");
      rd(HMI_OFS_ENABLE, HMI_ENABLE_RST, "enable after reset");
      rd(HMI_OFS_STATUS, HMI_STATUS_RST, "status after reset");
      irq_is(1'b0);
      $display("test reset done");
      close_out();
   end
endmodule

`default_nettype wire
